// ---- src/rac_dev.sv ----
`timescale 1ns/1ps
module rac_dev
    import rac_pkg::*;
(
    // user clock domain
    input  wire logic                  clk,
    input  wire logic                  rst,
    // serial link
    rac_if.dev                         link,
    // register write side, clk domain
    output logic                       wr_valid,
    output logic [RAC_ADDR_W-1:0]      wr_addr,
    output logic [RAC_DATA_W-1:0]      wr_data,
    // register read side, link domain
    output logic [RAC_ADDR_W-1:0]      rd_addr,
    input  wire logic [RAC_DATA_W-1:0] rd_data,
    // status, clk domain
    output logic                       cmd_err,
    output logic                       busy
);

    // R04 select high holds frame state in reset
    logic link_rst;
    assign link_rst = link.cs_n | rst;

    // frame state, rising edges of the link clock
    rac_dstate_t           state;
    rac_dstate_t           next_state;
    logic [RAC_BIT_W-1:0]  bit_cnt;
    logic [RAC_BIT_W-1:0]  next_bit_cnt;
    logic [14:0]           shreg;
    logic [14:0]           next_shreg;
    logic [RAC_ADDR_W-1:0] ptr;
    logic [RAC_ADDR_W-1:0] next_ptr;
    logic                  wr_stop;
    logic                  next_wr_stop;
    logic [RAC_DATA_W-1:0] word;
    logic                  word_end;
    logic                  wr_fire;
    logic                  err_fire;

    // R21 msb first
    assign word     = {shreg, link.sdi};
    assign word_end = (bit_cnt == RAC_LAST_BIT);
    assign rd_addr  = ptr;

    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt + 4'h1;
        next_shreg   = word[14:0];
        next_ptr     = ptr;
        next_wr_stop = wr_stop;
        wr_fire      = 1'b0;
        err_fire     = 1'b0;
        case (state)
            RAC_ST_CMD: begin
                if (word_end) begin
                    // R05 enable pattern check
                    if (word[RAC_ENA_HI:RAC_ENA_LO] == RAC_ENA_PAT) begin
                        // R07 start address
                        next_ptr = word[RAC_ADDR_W-1:0];
                        // R06 direction bit
                        next_state = word[RAC_RW_BIT] ? RAC_ST_RD : RAC_ST_WR;
                    end else begin
                        // R22 reject frame
                        next_state = RAC_ST_BAD;
                        err_fire   = 1'b1;
                    end
                end
            end
            RAC_ST_WR: begin
                // R08 store full word
                if (word_end && !wr_stop) begin
                    wr_fire = 1'b1;
                    // R10 stop at maximum
                    if (ptr == RAC_ADDR_MAX) begin
                        next_wr_stop = 1'b1;
                    end else begin
                        // R09 advance pointer
                        next_ptr = ptr + 10'h001;
                    end
                end
            end
            RAC_ST_RD: begin
                // R16 advance per word
                if (word_end && ptr != RAC_ADDR_MAX) begin
                    next_ptr = ptr + 10'h001;
                end
                // R17 pointer parks on last register
            end
            RAC_ST_BAD: begin
                next_state = RAC_ST_BAD;
            end
            default: begin
                next_state = RAC_ST_BAD;
            end
        endcase
    end

    // R01 sample on rising edge
    // R13 only rising edges count, so idle level is irrelevant
    always_ff @(posedge link.sclk or posedge link_rst) begin
        if (link_rst) begin
            state   <= RAC_ST_CMD;
            bit_cnt <= RAC_FIRST;
            shreg   <= 15'h0000;
            ptr     <= 10'h000;
            wr_stop <= 1'b0;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            ptr     <= next_ptr;
            wr_stop <= next_wr_stop;
        end
    end

    // hand-over words, link domain; kept across frames so a toggle
    // is never undone when select rises
    logic                  wr_tgl;
    logic                  next_wr_tgl;
    logic                  err_tgl;
    logic                  next_err_tgl;
    logic [RAC_ADDR_W-1:0] hand_addr;
    logic [RAC_ADDR_W-1:0] next_hand_addr;
    logic [RAC_DATA_W-1:0] hand_data;
    logic [RAC_DATA_W-1:0] next_hand_data;

    always_comb begin
        next_wr_tgl    = wr_tgl ^ wr_fire;
        next_err_tgl   = err_tgl ^ err_fire;
        next_hand_addr = wr_fire ? ptr : hand_addr;
        next_hand_data = wr_fire ? word : hand_data;
    end

    always_ff @(posedge link.sclk or posedge rst) begin
        if (rst) begin
            wr_tgl    <= 1'b0;
            err_tgl   <= 1'b0;
            hand_addr <= 10'h000;
            hand_data <= 16'h0000;
        end else begin
            wr_tgl    <= next_wr_tgl;
            err_tgl   <= next_err_tgl;
            hand_addr <= next_hand_addr;
            hand_data <= next_hand_data;
        end
    end

    // output shifter, falling edges of the link clock
    logic [RAC_DATA_W-1:0] sdo_sh;
    logic [RAC_DATA_W-1:0] next_sdo_sh;
    logic                  sdo_oe;
    logic                  next_sdo_oe;

    // rd_data is sampled straight on the link clock: the register file
    // must hold a word steady while it is being read back
    always_comb begin
        // R15 load on first falling edge after a word boundary
        if (state == RAC_ST_RD && bit_cnt == RAC_FIRST) begin
            next_sdo_sh = rd_data;
        end else begin
            next_sdo_sh = {sdo_sh[RAC_DATA_W-2:0], 1'b0};
        end
        // R19 drive only while returning data
        next_sdo_oe = (state == RAC_ST_RD);
    end

    // R02 output changes on falling edge
    always_ff @(negedge link.sclk or posedge link_rst) begin
        if (link_rst) begin
            sdo_sh <= 16'h0000;
            sdo_oe <= 1'b0;
        end else begin
            sdo_sh <= next_sdo_sh;
            sdo_oe <= next_sdo_oe;
        end
    end

    // R21 msb leaves first
    assign link.sdo_o  = sdo_sh[RAC_DATA_W-1];
    assign link.sdo_oe = sdo_oe;

    // clk domain: toggle synchronisers and select level
    logic [2:0]            wr_sync;
    logic [2:0]            next_wr_sync;
    logic [2:0]            err_sync;
    logic [2:0]            next_err_sync;
    logic [1:0]            sel_sync;
    logic [1:0]            next_sel_sync;
    logic                  next_wr_valid;
    logic [RAC_ADDR_W-1:0] next_wr_addr;
    logic [RAC_DATA_W-1:0] next_wr_data;
    logic                  next_cmd_err;

    always_comb begin
        next_wr_sync  = {wr_sync[1:0], wr_tgl};
        next_err_sync = {err_sync[1:0], err_tgl};
        next_sel_sync = {sel_sync[0], ~link.cs_n};
        next_wr_valid = wr_sync[2] ^ wr_sync[1];
        next_cmd_err  = err_sync[2] ^ err_sync[1];
        // hand words settled two clocks before the toggle arrives
        next_wr_addr  = next_wr_valid ? hand_addr : wr_addr;
        next_wr_data  = next_wr_valid ? hand_data : wr_data;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_sync  <= 3'h0;
            err_sync <= 3'h0;
            sel_sync <= 2'h0;
            wr_valid <= 1'b0;
            wr_addr  <= 10'h000;
            wr_data  <= 16'h0000;
            cmd_err  <= 1'b0;
        end else begin
            wr_sync  <= next_wr_sync;
            err_sync <= next_err_sync;
            sel_sync <= next_sel_sync;
            wr_valid <= next_wr_valid;
            wr_addr  <= next_wr_addr;
            wr_data  <= next_wr_data;
            cmd_err  <= next_cmd_err;
        end
    end

    assign busy = sel_sync[1];

endmodule : rac_dev

// ---- src/rac_pkg.sv ----
// Operation
// R01: device samples serial input on rising edges
// R02: device changes serial output on falling edges
// R03: master lowers select, sends command word first
// R04: high select idles the interface completely
// R05: top five command bits must read 11100
// R06: command bit ten: one read, zero write
// R07: low ten bits load the address pointer
// R08: write stores one data word per register
// R09: pointer increments after every written word
// R10: no wrap; writes past maximum are discarded
// R11: single write shifts exactly 32 bits
// R12: sequential write sends whole words, select low
// R13: serial clock may idle high or low
// R14: read needs sixteen clocks per word
// R15: first read bit on first falling edge
// R16: read returns successive registers, pointer increments
// R17: at maximum, read repeats the last register
// R18: read ends when master raises select
// R19: output released except while returning data
// R20: every register is sixteen bits wide
// R21: words travel most significant bit first
// R22: bad enable pattern ignores rest of frame
package rac_pkg;
    // R20 sixteen bit words
    localparam int          RAC_DATA_W   = 16;
    localparam int          RAC_ADDR_W   = 10;
    localparam int          RAC_CNT_W    = 11;
    localparam int          RAC_BIT_W    = 4;
    localparam int          RAC_DIV_W    = 8;
    localparam int          RAC_HALF_DEF = 4;
    localparam int          RAC_ENA_HI   = 15;
    localparam int          RAC_ENA_LO   = 11;
    localparam int          RAC_RW_BIT   = 10;
    localparam logic [4:0]  RAC_ENA_PAT  = 5'h1C;
    localparam logic [9:0]  RAC_ADDR_MAX = 10'h3FF;
    localparam logic [3:0]  RAC_LAST_BIT = 4'hF;
    localparam logic [3:0]  RAC_FIRST    = 4'h0;

    typedef enum logic [1:0] {
        RAC_ST_CMD = 2'b00,
        RAC_ST_WR  = 2'b01,
        RAC_ST_RD  = 2'b10,
        RAC_ST_BAD = 2'b11
    } rac_dstate_t;

    typedef enum logic [1:0] {
        RAC_H_IDLE = 2'b00,
        RAC_H_LEAD = 2'b01,
        RAC_H_RUN  = 2'b10,
        RAC_H_TAIL = 2'b11
    } rac_hstate_t;
endpackage : rac_pkg

// ---- src/rac_if.sv ----
`timescale 1ns/1ps
interface rac_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic sdo;

    // released line floats high through the bus pull-up
    assign sdo = sdo_oe ? sdo_o : 1'b1;

    modport dev (
        input  cs_n,
        input  sclk,
        input  sdi,
        output sdo_o,
        output sdo_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output sdi,
        input  sdo
    );
endinterface : rac_if

// ---- src/rac_host.sv ----
`timescale 1ns/1ps
module rac_host
    import rac_pkg::*;
#(
    parameter int HALF = RAC_HALF_DEF
)(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // serial link
    rac_if.host                        link,
    // request
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_read,
    input  wire logic [RAC_ADDR_W-1:0] req_addr,
    input  wire logic [RAC_CNT_W-1:0]  req_count,
    // write data
    input  wire logic [RAC_DATA_W-1:0] wr_data,
    output logic                       wr_take,
    // read data and completion
    output logic [RAC_DATA_W-1:0]      rd_data,
    output logic                       rd_valid,
    output logic                       done
);

    rac_hstate_t           state;
    rac_hstate_t           next_state;
    logic [RAC_DIV_W-1:0]  div;
    logic [RAC_DIV_W-1:0]  next_div;
    logic                  sclk;
    logic                  next_sclk;
    logic                  cs_n;
    logic                  next_cs_n;
    logic [RAC_DATA_W-1:0] txsh;
    logic [RAC_DATA_W-1:0] next_txsh;
    logic [RAC_DATA_W-1:0] rxsh;
    logic [RAC_DATA_W-1:0] next_rxsh;
    logic [RAC_BIT_W-1:0]  bitn;
    logic [RAC_BIT_W-1:0]  next_bitn;
    logic [RAC_CNT_W-1:0]  left;
    logic [RAC_CNT_W-1:0]  next_left;
    logic                  is_read;
    logic                  next_is_read;
    logic                  in_data;
    logic                  next_in_data;
    logic [RAC_DATA_W-1:0] next_rd_data;
    logic                  next_rd_valid;
    logic                  next_wr_take;
    logic                  next_done;
    logic [1:0]            sdo_sync;
    logic                  tick;

    localparam logic [RAC_DIV_W-1:0] DIV_LAST = RAC_DIV_W'(HALF - 1);

    assign tick      = (div == DIV_LAST);
    assign req_ready = (state == RAC_H_IDLE);

    always_comb begin
        next_state    = state;
        next_div      = div + 8'h01;
        next_sclk     = sclk;
        next_cs_n     = cs_n;
        next_txsh     = txsh;
        next_rxsh     = rxsh;
        next_bitn     = bitn;
        next_left     = left;
        next_is_read  = is_read;
        next_in_data  = in_data;
        next_rd_data  = rd_data;
        next_rd_valid = 1'b0;
        next_wr_take  = 1'b0;
        next_done     = 1'b0;
        case (state)
            RAC_H_IDLE: begin
                next_div = 8'h00;
                if (req_valid) begin
                    // R03 select low, command word first
                    // R05 R06 enable pattern and direction
                    next_cs_n    = 1'b0;
                    next_txsh    = {RAC_ENA_PAT, req_read, req_addr};
                    next_left    = req_count;
                    next_is_read = req_read;
                    next_in_data = 1'b0;
                    next_bitn    = RAC_FIRST;
                    next_state   = RAC_H_LEAD;
                end
            end
            RAC_H_LEAD: begin
                if (tick) begin
                    next_div   = 8'h00;
                    next_state = RAC_H_RUN;
                end
            end
            RAC_H_RUN: begin
                if (tick) begin
                    next_div  = 8'h00;
                    next_sclk = ~sclk;
                    if (sclk) begin
                        next_rxsh = {rxsh[RAC_DATA_W-2:0], sdo_sync[1]};
                        next_bitn = bitn + 4'h1;
                        // R21 shift msb first
                        next_txsh = {txsh[RAC_DATA_W-2:0], 1'b0};
                        if (bitn == RAC_LAST_BIT) begin
                            if (in_data && is_read) begin
                                next_rd_data  = next_rxsh;
                                next_rd_valid = 1'b1;
                            end
                            // R14 R12 whole words; R11 R18 select kept low
                            if (left == '0) begin
                                next_state = RAC_H_TAIL;
                            end else begin
                                next_left    = left - 11'h001;
                                next_in_data = 1'b1;
                                next_txsh    = is_read ? 16'h0000 : wr_data;
                                next_wr_take = ~is_read;
                            end
                        end
                    end
                end
            end
            RAC_H_TAIL: begin
                if (tick) begin
                    // R18 raise select to end
                    next_cs_n  = 1'b1;
                    next_done  = 1'b1;
                    next_state = RAC_H_IDLE;
                end
            end
            default: begin
                next_state = RAC_H_IDLE;
                next_cs_n  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= RAC_H_IDLE;
            div      <= 8'h00;
            sclk     <= 1'b0;
            cs_n     <= 1'b1;
            txsh     <= 16'h0000;
            rxsh     <= 16'h0000;
            bitn     <= RAC_FIRST;
            left     <= 11'h000;
            is_read  <= 1'b0;
            in_data  <= 1'b0;
            rd_data  <= 16'h0000;
            rd_valid <= 1'b0;
            wr_take  <= 1'b0;
            done     <= 1'b0;
            sdo_sync <= 2'h0;
        end else begin
            state    <= next_state;
            div      <= next_div;
            sclk     <= next_sclk;
            cs_n     <= next_cs_n;
            txsh     <= next_txsh;
            rxsh     <= next_rxsh;
            bitn     <= next_bitn;
            left     <= next_left;
            is_read  <= next_is_read;
            in_data  <= next_in_data;
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            wr_take  <= next_wr_take;
            done     <= next_done;
            sdo_sync <= {sdo_sync[0], link.sdo};
        end
    end

    assign link.cs_n = cs_n;
    assign link.sclk = sclk;
    assign link.sdi  = txsh[RAC_DATA_W-1];

endmodule : rac_host

// ---- bench/rac_props.sv ----
`timescale 1ns/1ps
module rac_props
    import rac_pkg::*;
(
    // host clock domain
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    logic        sclk_q;
    logic        next_sclk_q;
    logic [15:0] rise_cnt;
    logic [15:0] next_rise_cnt;
    logic [15:0] cmd;
    logic [15:0] next_cmd;
    logic        rd_ok;

    // sclk is made from clk, so sampling on clk misses no edge
    always_comb begin
        next_sclk_q   = sclk;
        next_rise_cnt = rise_cnt;
        next_cmd      = cmd;
        if (cs_n) begin
            next_rise_cnt = 16'h0000;
        end else if (sclk && !sclk_q) begin
            next_rise_cnt = rise_cnt + 16'h0001;
            if (rise_cnt < 16'h0010) begin
                next_cmd = {cmd[14:0], sdi};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q   <= 1'b0;
            rise_cnt <= 16'h0000;
            cmd      <= 16'h0000;
        end else begin
            sclk_q   <= next_sclk_q;
            rise_cnt <= next_rise_cnt;
            cmd      <= next_cmd;
        end
    end

    assign rd_ok = (cmd[RAC_ENA_HI:RAC_ENA_LO] == RAC_ENA_PAT) && cmd[RAC_RW_BIT];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_sel_idle: assert property (cs_n |-> !sdo_oe && !sclk)
        else $error("link active while deselected");
    a_no_drive_early: assert property (!cs_n && (rise_cnt < 16'h0010 || !rd_ok) |-> !sdo_oe)
        else $error("output driven outside read data");
    a_read_drives: assert property (
        !cs_n && rd_ok && rise_cnt >= 16'h0010 && !sclk |-> sdo_oe)
        else $error("read data not driven after command");
    a_sdo_fall_only: assert property (sclk && sdo_oe |-> $stable(sdo_o))
        else $error("output changed outside a falling edge");
    a_oe_on_fall: assert property ($rose(sdo_oe) |-> $fell(sclk))
        else $error("output enabled off a falling edge");
    a_sdi_hold_high: assert property (sclk |-> $stable(sdi) && !cs_n)
        else $error("input moved while clock high");
    a_whole_words: assert property (
        $rose(cs_n) |-> rise_cnt[3:0] == 4'h0 && rise_cnt >= 16'h0010)
        else $error("frame not whole words");
    a_lead_low: assert property ($fell(cs_n) |-> !sclk ##[1:8] $rose(sclk))
        else $error("select lead wrong");

    cover property ($rose(sdo_oe));
    cover property ($rose(cs_n) && rise_cnt == 16'h0010);
    cover property ($rose(cs_n) && rise_cnt >= 16'h0040);
endmodule : rac_props

// ---- bench/spi_register_access_slave_tb.sv ----
`timescale 1ns/1ps
module spi_register_access_slave_tb;
    import rac_pkg::*;
    localparam int HALF = 2;
    logic                  clk;
    logic                  rst;
    logic                  req_valid;
    logic                  req_ready;
    logic                  req_read;
    logic [RAC_ADDR_W-1:0] req_addr;
    logic [RAC_CNT_W-1:0]  req_count;
    logic [RAC_DATA_W-1:0] h_wdata;
    logic                  wr_take;
    logic [RAC_DATA_W-1:0] h_rdata;
    logic                  rd_valid;
    logic                  done;
    logic                  wv_a, wv_b, err_a, err_b, busy_a;
    logic [RAC_ADDR_W-1:0] wa_a, wa_b, ra_a, ra_b, a;
    logic [RAC_DATA_W-1:0] wd_a, wd_b, rdd_a, rdd_b, d;
    logic [15:0]           dev_mem [1024];
    logic [15:0]           exp_mem [1024];
    logic [25:0]           ewq [$];
    logic [15:0]           rq [$];
    logic [15:0]           wbuf [$];
    logic [25:0]           wlast_b;
    logic [47:0]           got;
    int                    err_total, n_checks, cerr_a, cerr_b, wv_cnt_b;

    rac_if la ();
    rac_if lb ();
    rac_host #(.HALF(HALF)) i_rac_host (.clk(clk), .rst(rst), .link(la),
        .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
        .req_addr(req_addr), .req_count(req_count), .wr_data(h_wdata), .wr_take(wr_take),
        .rd_data(h_rdata), .rd_valid(rd_valid), .done(done));
    rac_dev i_rac_dev (.clk(clk), .rst(rst), .link(la), .wr_valid(wv_a), .wr_addr(wa_a),
        .wr_data(wd_a), .rd_addr(ra_a), .rd_data(rdd_a), .cmd_err(err_a), .busy(busy_a));
    // second device faces the bench driver that can break the rules
    rac_dev i_rac_dev_b (.clk(clk), .rst(rst), .link(lb), .wr_valid(wv_b), .wr_addr(wa_b),
        .wr_data(wd_b), .rd_addr(ra_b), .rd_data(rdd_b), .cmd_err(err_b), .busy());
    rac_props i_rac_props (.clk(clk), .rst(rst), .cs_n(la.cs_n), .sclk(la.sclk),
        .sdi(la.sdi), .sdo_o(la.sdo_o), .sdo_oe(la.sdo_oe));

    assign rdd_a = dev_mem[ra_a];
    assign rdd_b = far_word(ra_b);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // pointer parks on the top register once a read runs past the map
    function automatic logic [15:0] rd_expect(input logic [10:0] p);
        return exp_mem[p > 11'h3FF ? 10'h3FF : p[9:0]];
    endfunction : rd_expect

    // fixed pattern served by the register model of the far device
    function automatic logic [15:0] far_word(input logic [9:0] adr);
        return {6'h00, adr} ^ 16'hC3C3;
    endfunction : far_word

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(negedge clk) begin
        if (wr_take === 1'b1 && wbuf.size() > 0) begin
            void'(wbuf.pop_front());
            if (wbuf.size() > 0) h_wdata = wbuf[0];
        end
        if (rd_valid === 1'b1) rq.push_back(h_rdata);
        if (wv_a === 1'b1) begin
            check(32'({wa_a, wd_a}), 32'(ewq.size() > 0 ? ewq.pop_front() : 26'h0));
            dev_mem[wa_a] = wd_a;
        end
        if (wv_b === 1'b1) begin
            wv_cnt_b++;
            wlast_b = {wa_b, wd_b};
        end
        if (err_a === 1'b1) cerr_a++;
        if (err_b === 1'b1) cerr_b++;
    end

    task automatic xfer(input logic rd, input logic [9:0] adr, input int n);
        int          t;
        logic [10:0] p;
        wbuf.delete();
        for (int i = 0; i < n; i++) begin
            p = 11'(adr) + 11'(i);
            wbuf.push_back(16'($urandom));
            if (!rd && p <= 11'h3FF) begin
                exp_mem[p[9:0]] = wbuf[i];
                ewq.push_back({p[9:0], wbuf[i]});
            end
        end
        h_wdata   = wbuf.size() > 0 ? wbuf[0] : 16'h0000;
        req_read  = rd;
        req_addr  = adr;
        req_count = RAC_CNT_W'(n);
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 5000) begin
            @(negedge clk);
            if (t == 40) check(32'(busy_a), 1);
            if (t == 40) check(32'(req_ready), 0);
            t++;
        end
        check(32'(t < 5000), 1);
        repeat (6) @(negedge clk);
        check(32'(busy_a), 0);
        check(32'(req_ready), 1);
        if (rd) begin
            check(rq.size(), n);
            for (int i = 0; i < n; i++) begin
                p = 11'(adr) + 11'(i);
                check(32'(rq.pop_front()), 32'(rd_expect(p)));
            end
        end
        check(ewq.size(), 0);
    endtask : xfer

    // bench link clock idles high, 64 ns period
    task automatic bframe(input logic [47:0] w, input int n);
        got = '0;
        lb.cs_n = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            lb.sclk = 1'b0;
            lb.sdi  = w[47-i];
            #32;
            lb.sclk = 1'b1;
            if (i < 16) check(32'(lb.sdo_oe), 0);
            got = {got[46:0], lb.sdo};
            #32;
        end
        lb.cs_n = 1'b1;
        lb.sdi  = ~lb.sdi;
        #200;
        repeat (10) @(negedge clk);
    endtask : bframe

    initial begin
        #2_000_000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_addr = '0;
        req_count = '0;
        h_wdata = '0;
        lb.cs_n = 1'b1;
        lb.sclk = 1'b1;
        lb.sdi = 1'b0;
        for (int i = 0; i < 1024; i++) begin
            dev_mem[i] = 16'(i) ^ 16'h5A5A;
            exp_mem[i] = 16'(i) ^ 16'h5A5A;
        end
        void'($urandom(19));
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        a = 10'($urandom);
        xfer(1'b0, a, 1);
        xfer(1'b1, a, 1);
        $display("test single done");
        a = 10'($urandom) & 10'h3F0;
        xfer(1'b0, a, 3);
        xfer(1'b1, a, 3);
        xfer(1'b0, a, 0);
        xfer(1'b1, a, 0);
        $display("test sequential done");
        xfer(1'b0, 10'h3FE, 3);
        xfer(1'b1, 10'h3FE, 4);
        $display("test top of map done");
        repeat (8) xfer(1'($urandom), 10'($urandom), 1 + int'($urandom % 4));
        check(cerr_a, 0);
        $display("test random done");
        // every single-bit error in the enable field
        for (int k = 0; k < 5; k++) begin
            bframe({RAC_ENA_PAT ^ 5'(1 << k), 1'b1, a, 16'hFFFF, 16'h0000}, 32);
            check(got[31:0], 32'hFFFF_FFFF);
        end
        check(cerr_b, 5);
        check(wv_cnt_b, 0);
        d = 16'($urandom);
        bframe({RAC_ENA_PAT, 1'b0, a, d, 16'h5555}, 39);
        check(wv_cnt_b, 1);
        check(32'(wlast_b), 32'({a, d}));
        bframe({RAC_ENA_PAT, 1'b1, a, 16'h0000, 16'h0000}, 32);
        check(32'(got[15:0]), 32'(far_word(a)));
        $display("test far link done");
        tally_and_finish();
    end
endmodule : spi_register_access_slave_tb
